// >>> hw/timer_counter_params.svh
`ifndef TIMER_COUNTER_PARAMS_SVH
`define TIMER_COUNTER_PARAMS_SVH

// ============================================================
// Register byte offsets
`define OFS_COUNTER_CONTROL 12'h000
`define OFS_COUNT_LOW_BYTE 12'h004
`define OFS_COUNT_HIGH_BYTE 12'h008
`define OFS_IRQ_STATUS 12'h00c
`define OFS_IRQ_MASK 12'h010

// ============================================================
// Control register fields
`define BIT_WIDE_ACCESS_ENABLE 7
`define BIT_PRESCALE_HI 5
`define BIT_PRESCALE_LO 4
`define BIT_CAPTURE_TIMEBASE_SELECT 3
`define BIT_EXT_SYNC_DISABLE 2
`define BIT_CLOCK_SOURCE_SELECT 1
`define BIT_COUNTER_ON 0
`define CONTROL_WRITE_MASK 8'hbf
`define CONTROL_RESET 8'h00

// ============================================================
// Interrupt fields and reset values
`define BIT_OVERFLOW_FLAG 0
`define IRQ_RESET 1'h0
`define COUNT_RESET 16'h0000
`define COUNT_MAX 16'hffff

// ============================================================
// Timing: instruction cycle is four oscillator (pclk) cycles
`define INSTR_DIV 3'h4

`endif

// >>> hw/timer_counter_pkg.sv
package timer_counter_pkg;

    // Prescale select codes of the counting clock
    typedef enum logic [1:0] {
        PRESCALE_1 = 2'b00,
        PRESCALE_2 = 2'b01,
        PRESCALE_4 = 2'b10,
        PRESCALE_8 = 2'b11
    } prescale_t;

endpackage

// >>> hw/sixteen_bit_timer_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_counter_params.svh"

module sixteen_bit_timer_counter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_clock_pin,
    input wire logic aux_osc_clk,
    input wire logic aux_osc_enable,
    input wire logic special_event_trigger,
    input wire logic [1:0] osc_pins_in,
    input wire logic [1:0] port_a_direction,
    output logic [1:0] osc_pins_read,
    output logic [1:0] osc_pins_dir_eff,
    output logic osc_pins_input_en,
    output logic [15:0] count_value,
    output logic capture_timebase_select,
    output logic irq
);

    // ========================================================
    // Registers and decode
    logic [7:0] counter_control_reg, high_buffer_reg;
    logic [15:0] count_reg;
    logic [0:0] irq_status_reg, irq_mask_reg;
    logic [2:0] presc_reg, instr_div_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg, irq_reg, osc_inen_reg, fall_seen_reg;
    logic [1:0] osc_read_reg, osc_dir_reg;
    logic sync1_reg, sync2_reg, sync3_reg, async1_reg, async2_reg;

    logic wide_mode, source_ext, sync_off, counter_on;
    timer_counter_pkg::prescale_t prescale_sel;
    logic access, done, wr_done, rd_start, addr_hit;
    logic wr_low, wr_high, wr_count, rd_low, trig;
    logic ext_in, ext_rise, ext_fall, instr_tick, src_tick;
    logic [2:0] presc_limit;
    logic presc_hit, count_tick, overflow_event;
    logic [31:0] rd_value;

    assign wide_mode = counter_control_reg[`BIT_WIDE_ACCESS_ENABLE];
    assign source_ext = counter_control_reg[`BIT_CLOCK_SOURCE_SELECT];
    assign sync_off = counter_control_reg[`BIT_EXT_SYNC_DISABLE];
    assign counter_on = counter_control_reg[`BIT_COUNTER_ON];
    assign prescale_sel = timer_counter_pkg::prescale_t'(
        counter_control_reg[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO]);

    // One wait state: read data is latched in the first access cycle
    assign access = psel && penable;
    assign done = access && pready_reg;
    assign wr_done = done && pwrite;
    assign rd_start = access && !pready_reg && !pwrite;
    assign addr_hit = (paddr == `OFS_COUNTER_CONTROL) ||
                      (paddr == `OFS_COUNT_LOW_BYTE) ||
                      (paddr == `OFS_COUNT_HIGH_BYTE) ||
                      (paddr == `OFS_IRQ_STATUS) ||
                      (paddr == `OFS_IRQ_MASK);
    assign wr_low = wr_done && (paddr == `OFS_COUNT_LOW_BYTE);
    assign wr_high = wr_done && (paddr == `OFS_COUNT_HIGH_BYTE);
    assign wr_count = wr_low || (wr_high && !wide_mode);
    assign rd_low = rd_start && (paddr == `OFS_COUNT_LOW_BYTE);
    assign trig = special_event_trigger && capture_timebase_select;

    // ========================================================
    // APB slave
    always_comb begin
        rd_value = 32'h0000_0000;
        unique case (paddr)
            `OFS_COUNTER_CONTROL: rd_value[7:0] = counter_control_reg;
            `OFS_COUNT_LOW_BYTE: rd_value[7:0] = count_reg[7:0];
            `OFS_COUNT_HIGH_BYTE: begin
                if (wide_mode) begin
                    rd_value[7:0] = high_buffer_reg;
                end else begin
                    rd_value[7:0] = count_reg[15:8];
                end
            end
            `OFS_IRQ_STATUS: rd_value[0] = irq_status_reg[0];
            `OFS_IRQ_MASK: rd_value[0] = irq_mask_reg[0];
            default: rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (access && !pready_reg) begin
            pready_reg <= 1'b1;
            pslverr_reg <= !addr_hit;
            if (!pwrite) begin
                prdata_reg <= rd_value;
            end
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_control_reg <= `CONTROL_RESET;
        end else if (wr_done && paddr == `OFS_COUNTER_CONTROL) begin
            counter_control_reg <= pwdata[7:0] & `CONTROL_WRITE_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= `IRQ_RESET;
        end else if (wr_done && paddr == `OFS_IRQ_MASK) begin
            irq_mask_reg[0] <= pwdata[`BIT_OVERFLOW_FLAG];
        end
    end

    // ========================================================
    // High-byte buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_buffer_reg <= 8'h00;
        end else if (wide_mode && rd_low) begin
            high_buffer_reg <= count_reg[15:8];
        end else if (wide_mode && wr_high) begin
            high_buffer_reg <= pwdata[7:0];
        end
    end

    // ========================================================
    // Clock sources
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_div_reg <= 3'h0;
        end else if (instr_div_reg == `INSTR_DIV - 3'h1) begin
            instr_div_reg <= 3'h0;
        end else begin
            instr_div_reg <= instr_div_reg + 3'h1;
        end
    end
    assign instr_tick = (instr_div_reg == `INSTR_DIV - 3'h1);

    // Aux oscillator takes over the external input when enabled
    assign ext_in = aux_osc_enable ? aux_osc_clk : ext_clock_pin;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            async1_reg <= 1'b0;
            async2_reg <= 1'b0;
        end else begin
            sync1_reg <= ext_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            async1_reg <= ext_in;
            async2_reg <= async1_reg;
        end
    end

    // Unsynchronised path uses one register stage in place of the two-stage synchroniser
    always_comb begin
        if (sync_off) begin
            ext_rise = async1_reg && !async2_reg;
            ext_fall = !async1_reg && async2_reg;
        end else begin
            ext_rise = sync2_reg && !sync3_reg;
            ext_fall = !sync2_reg && sync3_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fall_seen_reg <= 1'b0;
        end else if (!source_ext) begin
            fall_seen_reg <= 1'b0;
        end else if (ext_fall) begin
            fall_seen_reg <= 1'b1;
        end
    end

    always_comb begin
        if (source_ext) begin
            src_tick = ext_rise && fall_seen_reg;
        end else begin
            src_tick = instr_tick;
        end
    end

    // ========================================================
    // Prescaler
    always_comb begin
        unique case (prescale_sel)
            timer_counter_pkg::PRESCALE_1: presc_limit = 3'h0;
            timer_counter_pkg::PRESCALE_2: presc_limit = 3'h1;
            timer_counter_pkg::PRESCALE_4: presc_limit = 3'h3;
            timer_counter_pkg::PRESCALE_8: presc_limit = 3'h7;
        endcase
    end
    assign presc_hit = (presc_reg == presc_limit);
    assign count_tick = counter_on && src_tick && presc_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_reg <= 3'h0;
        end else if (wr_low) begin
            presc_reg <= 3'h0;
        end else if (counter_on && src_tick) begin
            presc_reg <= presc_hit ? 3'h0 : presc_reg + 3'h1;
        end
    end

    // ========================================================
    // Counter
    assign overflow_event = count_tick && !wr_count && !trig &&
                            (count_reg == `COUNT_MAX);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= `COUNT_RESET;
        end else if (wr_low) begin
            count_reg[7:0] <= pwdata[7:0];
            if (wide_mode) begin
                count_reg[15:8] <= high_buffer_reg;
            end
        end else if (wr_high && !wide_mode) begin
            count_reg[15:8] <= pwdata[7:0];
        end else if (trig) begin
            count_reg <= `COUNT_RESET;
        end else if (count_tick) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // ========================================================
    // Interrupts: set wins over write-one-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= `IRQ_RESET;
        end else if (overflow_event) begin
            irq_status_reg[0] <= 1'b1;
        end else if (wr_done && paddr == `OFS_IRQ_STATUS &&
                     pwdata[`BIT_OVERFLOW_FLAG]) begin
            irq_status_reg[0] <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_status_reg[0] && irq_mask_reg[0];
        end
    end

    // ========================================================
    // Oscillator pin handling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_read_reg <= 2'h0;
            osc_dir_reg <= 2'h0;
            osc_inen_reg <= 1'b0;
        end else begin
            osc_read_reg <= aux_osc_enable ? 2'h0 : osc_pins_in;
            osc_dir_reg <= aux_osc_enable ? 2'h0 : port_a_direction;
            osc_inen_reg <= !aux_osc_enable;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign osc_pins_read = osc_read_reg;
    assign osc_pins_dir_eff = osc_dir_reg;
    assign osc_pins_input_en = osc_inen_reg;
    assign count_value = count_reg;
    assign capture_timebase_select =
        counter_control_reg[`BIT_CAPTURE_TIMEBASE_SELECT];
    assign irq = irq_reg;

    // ========================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_instr_tick_rate:
        assert property (instr_tick |=> !instr_tick [*3] ##1 instr_tick)
        else $error("instruction tick spacing wrong");
    a_no_count_before_fall:
        assert property (source_ext && !fall_seen_reg |-> !count_tick)
        else $error("external count before first falling edge");
    a_prescale_period:
        assert property (counter_on && src_tick && !wr_low &&
                         presc_reg == 3'h0 &&
                         prescale_sel == timer_counter_pkg::PRESCALE_2
                         |-> !count_tick ##1 presc_reg == 3'h1)
        else $error("divide by two prescale wrong");
    a_hold_when_off:
        assert property (!counter_on && !wr_count && !trig
                         |=> count_reg == $past(count_reg))
        else $error("counter moved while off");
    a_wide_read_copy:
        assert property (wide_mode && rd_low
                         |=> high_buffer_reg == $past(count_reg[15:8]))
        else $error("high buffer not loaded on low read");
    a_wide_write_load:
        assert property (wide_mode && wr_low
                         |=> count_reg == {$past(high_buffer_reg),
                                           $past(pwdata[7:0])})
        else $error("16-bit write did not load both halves");
    a_high_isolated:
        assert property (wide_mode && wr_high && !count_tick && !trig
                         |=> count_reg == $past(count_reg))
        else $error("buffered high write reached live count");
    a_presc_clear:
        assert property (wr_low |=> presc_reg == 3'h0)
        else $error("prescaler not cleared by low write");
    a_osc_pins_zero:
        assert property (aux_osc_enable
                         |=> osc_pins_read == 2'h0 && !osc_pins_input_en)
        else $error("oscillator pins not masked");
    a_wrap_flag:
        assert property (overflow_event
                         |=> count_reg == 16'h0000 && irq_status_reg[0]
                         ##1 irq == $past(irq_mask_reg[0]))
        else $error("wrap did not clear count or raise flag");
    a_trigger_clear:
        assert property (trig && !wr_count |=> count_reg == 16'h0000)
        else $error("special event trigger did not clear count");
    a_write_wins:
        assert property (trig && wr_low
                         |=> count_reg[7:0] == $past(pwdata[7:0]))
        else $error("trigger overrode a software write");
    c_overflow: cover property (overflow_event ##2 irq);
    c_trigger: cover property (trig ##1 count_reg == 16'h0000);
    c_wide_read: cover property (wide_mode && rd_low);
    c_ext_count: cover property (source_ext && count_tick);

endmodule

`default_nettype wire

// >>> verification/ext_clock_source.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Far-side count clock: a frame of pulses, low between frames
module ext_clock_source #(
    parameter int HALF = 3
) (
    input wire logic pclk,
    input wire logic go,
    input wire logic [7:0] n_pulses,
    output logic busy,
    output logic clk_out
);
    initial begin
        clk_out = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge pclk);
            if (go === 1'b1) begin
                busy <= 1'b1;
                repeat (n_pulses) begin
                    clk_out <= 1'b1;
                    repeat (HALF) @(posedge pclk);
                    clk_out <= 1'b0;
                    repeat (HALF) @(posedge pclk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// >>> verification/sixteen_bit_timer_counter_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_counter_params.svh"

module sixteen_bit_timer_counter_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic ext_clock_pin, aux_osc_clk, aux_osc_enable, special_event_trigger;
    logic osc_pins_input_en, capture_timebase_select, irq;
    logic [1:0] osc_pins_in, port_a_direction, osc_pins_read, osc_pins_dir_eff;
    logic [15:0] count_value;
    logic pin_go, aux_go, pin_busy, aux_busy;
    logic [7:0] n_pulses;
    int n_errors, comparisons;

    sixteen_bit_timer_counter u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_clock_pin(ext_clock_pin),
        .aux_osc_clk(aux_osc_clk), .aux_osc_enable(aux_osc_enable),
        .special_event_trigger(special_event_trigger),
        .osc_pins_in(osc_pins_in), .port_a_direction(port_a_direction),
        .osc_pins_read(osc_pins_read), .osc_pins_dir_eff(osc_pins_dir_eff),
        .osc_pins_input_en(osc_pins_input_en), .count_value(count_value),
        .capture_timebase_select(capture_timebase_select), .irq(irq)
    );
    ext_clock_source #(.HALF(5)) u_pin (
        .pclk(pclk), .go(pin_go), .n_pulses(n_pulses), .busy(pin_busy),
        .clk_out(ext_clock_pin)
    );
    ext_clock_source #(.HALF(2)) u_aux (
        .pclk(pclk), .go(aux_go), .n_pulses(n_pulses), .busy(aux_busy),
        .clk_out(aux_osc_clk)
    );

    // ============================================================
    // Shared tasks
    task automatic report_and_stop();
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask

    task automatic wait_change(output int n);
        logic [15:0] v;
        v = count_value;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (count_value === v && n < 100);
    endtask

    task automatic set_count(input logic [15:0] v);
        wr(`OFS_COUNT_HIGH_BYTE, {24'h0, v[15:8]});
        wr(`OFS_COUNT_LOW_BYTE, {24'h0, v[7:0]});
    endtask

    // ============================================================
    // Scenarios
    task automatic t_regs();
        logic [31:0] q;
        logic e;
        rd(`OFS_COUNTER_CONTROL, q);
        chk(q, 32'h0);
        wr(`OFS_COUNTER_CONTROL, 32'hff);
        rd(`OFS_COUNTER_CONTROL, q);
        chk(q, 32'hbf);
        wr(`OFS_COUNTER_CONTROL, 32'h0);
        apb(1'b0, 12'h020, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
    endtask

    task automatic t_prescale();
        int n;
        logic [15:0] v;
        for (int c = 0; c < 4; c++) begin
            wr(`OFS_COUNTER_CONTROL, 32'(c << 4) | 32'h1);
            wait_change(n);
            wait_change(n);
            wait_change(n);
            chk(32'(n), 32'(4 << c));
        end
        wr(`OFS_COUNTER_CONTROL, 32'h30);
        v = count_value;
        repeat (40) @(posedge pclk);
        chk({16'h0, count_value}, {16'h0, v});
    endtask

    task automatic t_ext(input logic aux, input logic sync_off,
                         input logic [7:0] n);
        int k;
        wr(`OFS_COUNTER_CONTROL, 32'h0);
        set_count(16'h0000);
        aux_osc_enable <= aux;
        n_pulses <= n;
        wr(`OFS_COUNTER_CONTROL, {29'h0, sync_off, 2'b11});
        if (aux) aux_go <= 1'b1;
        else pin_go <= 1'b1;
        @(posedge pclk);
        aux_go <= 1'b0;
        pin_go <= 1'b0;
        @(posedge pclk);
        k = 0;
        while ((pin_busy | aux_busy) && k < 500) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 500) n_errors++;
        repeat (6) @(posedge pclk);
        chk({16'h0, count_value}, 32'(n - 1));
    endtask

    task automatic t_wide();
        logic [31:0] q;
        wr(`OFS_COUNTER_CONTROL, 32'h80);
        set_count(16'h1234);
        chk({16'h0, count_value}, 32'h1234);
        rd(`OFS_COUNT_HIGH_BYTE, q);
        chk(q, 32'h12);
        wr(`OFS_COUNT_HIGH_BYTE, 32'hab);
        chk({16'h0, count_value}, 32'h1234);
        rd(`OFS_COUNT_LOW_BYTE, q);
        chk(q, 32'h34);
        rd(`OFS_COUNT_HIGH_BYTE, q);
        chk(q, 32'h12);
        wr(`OFS_COUNTER_CONTROL, 32'h00);
        wr(`OFS_COUNT_HIGH_BYTE, 32'h56);
        chk({16'h0, count_value}, 32'h5634);
    endtask

    task automatic t_overflow();
        logic [31:0] q;
        int k;
        wr(`OFS_COUNTER_CONTROL, 32'h00);
        set_count(16'hfffe);
        wr(`OFS_COUNTER_CONTROL, 32'h01);
        k = 0;
        while (count_value !== 16'h0000 && k < 100) begin
            @(posedge pclk);
            k++;
        end
        chk({16'h0, count_value}, 32'h0);
        rd(`OFS_IRQ_STATUS, q);
        chk(q, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(`OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        wr(`OFS_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rd(`OFS_IRQ_STATUS, q);
        chk(q, 32'h0);
    endtask

    task automatic pulse_trigger();
        special_event_trigger <= 1'b1;
        @(posedge pclk);
        special_event_trigger <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    task automatic t_trigger();
        wr(`OFS_COUNTER_CONTROL, 32'h00);
        set_count(16'h0155);
        pulse_trigger();
        chk({16'h0, count_value}, 32'h0155);
        wr(`OFS_COUNTER_CONTROL, 32'h08);
        chk({31'h0, capture_timebase_select}, 32'h1);
        pulse_trigger();
        chk({16'h0, count_value}, 32'h0);
        fork
            wr(`OFS_COUNT_LOW_BYTE, 32'h77);
            begin
                @(posedge pready);
                special_event_trigger <= 1'b1;
                @(posedge pclk);
                special_event_trigger <= 1'b0;
            end
        join
        chk({16'h0, count_value}, 32'h0077);
        wr(`OFS_COUNTER_CONTROL, 32'h00);
        chk({31'h0, capture_timebase_select}, 32'h0);
    endtask

    task automatic t_reset();
        wr(`OFS_COUNTER_CONTROL, 32'h08);
        set_count(16'h00aa);
        presetn <= 1'b0;
        @(posedge pclk);
        chk({16'h0, count_value}, 32'h0);
        chk({31'h0, capture_timebase_select}, 32'h0);
        chk({31'h0, pready}, 32'h0);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk({16'h0, count_value}, 32'h0);
    endtask

    task automatic t_osc();
        aux_osc_enable <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({30'h0, osc_pins_read}, 32'h2);
        chk({30'h0, osc_pins_dir_eff}, 32'h1);
        chk({31'h0, osc_pins_input_en}, 32'h1);
        aux_osc_enable <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({30'h0, osc_pins_read}, 32'h0);
        chk({30'h0, osc_pins_dir_eff}, 32'h0);
        chk({31'h0, osc_pins_input_en}, 32'h0);
        aux_osc_enable <= 1'b0;
    endtask

    // ============================================================
    // Clock, watchdog and main sequence
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    initial begin
        #200000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        n_errors = 0;
        comparisons = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {aux_osc_enable, special_event_trigger, pin_go, aux_go} = '0;
        osc_pins_in = 2'b10;
        port_a_direction = 2'b01;
        n_pulses = 8'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_prescale();
        t_ext(1'b0, 1'b0, 8'h05);
        t_ext(1'b0, 1'b1, 8'h05);
        t_ext(1'b1, 1'b0, 8'h04);
        t_wide();
        t_overflow();
        t_trigger();
        t_reset();
        t_osc();
        report_and_stop();
    end
endmodule

`default_nettype wire
